// >>> verification/ext_bus_ctrl_monitor.sv
// Checker on the bus control block ports
`timescale 1ns/1ns
module ext_bus_ctrl_monitor (
  input wire       clk_in, rst_in, is_master_in, ack_in,                // Clock, reset, pins
  input wire       suspend_bus_tristate_n_in, host_bus_request_n_in,     // Host side pins
  input wire       bus_oe_n_out, read_strobe_n_out, write_strobe_n_out,  // Bus drive
  input wire       early_write_select_n_out, page_out, access_done_out,  // Access state
  input wire [3:0] memory_bank_select_n_out,                             // Bank selects
  input wire       host_bus_grant_n_out, host_access_ready_oe_n_out,     // Host answers
  input wire       ack_out, ack_oe_n_out, slave_access_out               // Slave ack
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ----------------------------------------
  // Bus master access
  // ----------------------------------------
  master_drives_a: assert property (!bus_oe_n_out |-> $past(is_master_in))
    else $error("bus driven while not master");
  read_strobe_a: assert property ($fell(read_strobe_n_out) |-> !bus_oe_n_out && early_write_select_n_out)
    else $error("read strobe without driven read cycle");
  write_strobe_a: assert property ($fell(write_strobe_n_out) |-> !$past(early_write_select_n_out))
    else $error("write strobe without early write");
  early_write_a: assert property ($fell(early_write_select_n_out) |-> read_strobe_n_out && write_strobe_n_out && !bus_oe_n_out)
    else $error("early write not in address phase");
  page_bank0_a: assert property (page_out |-> memory_bank_select_n_out == 4'hE)
    else $error("page flag outside bank 0");
  ack_hold_a: assert property (!ack_in [*5] |-> !access_done_out)
    else $error("access done with ack low");
  bank_idle_a: assert property (access_done_out |-> memory_bank_select_n_out == 4'hF && read_strobe_n_out)
    else $error("banks active at access end");
  // ----------------------------------------
  // Suspend, host and slave answers
  // ----------------------------------------
  suspend_float_a: assert property (!suspend_bus_tristate_n_in [*3] |=> bus_oe_n_out)
    else $error("bus driven under suspend");
  grant_float_a: assert property (!host_bus_grant_n_out |-> bus_oe_n_out)
    else $error("grant while bus driven");
  grant_hold_a: assert property (!host_bus_grant_n_out && !host_bus_request_n_in |=> !host_bus_grant_n_out)
    else $error("grant dropped while requested");
  ready_gate_a: assert property (host_bus_request_n_in [*4] |-> host_access_ready_oe_n_out)
    else $error("ready driven without request");
  slave_ack_a: assert property ($rose(slave_access_out) |-> (!ack_out && !ack_oe_n_out) [*3] ##1 (ack_out && !ack_oe_n_out))
    else $error("slave wait states wrong");
endmodule
bind ext_bus_ctrl ext_bus_ctrl_monitor mon (.*);

// >>> verification/ext_bus_ctrl_tb.sv
// Testbench for the shared external bus control block
`timescale 1ns/1ns
`include "ext_bus_map.vh"
module ext_bus_ctrl_tb;
  logic        clk_in, rst_in, is_master_in, req_in, req_write_in, req_cond_in, slave_hit_in;
  logic [31:0] req_addr_in;
  logic [2:0]  page_size_in;
  logic [5:0]  multiproc_bus_request_n_in;
  logic        suspend_bus_tristate_n_in, host_bus_request_n_in, host_select_proc_a_n_in;
  logic        host_select_proc_b_n_in, host_select_proc_c_n_in, host_select_proc_d_n_in;
  logic        ext_rd_n, ext_wr_n, ext_sw_n;
  logic [3:0]  mem_wait;
  wire  [31:0] address_out;
  wire  [3:0]  memory_bank_select_n_out;
  wire         read_strobe_n_out, write_strobe_n_out, early_write_select_n_out, page_out;
  wire         bus_clock_reference_out, bus_oe_n_out, ack_out, ack_oe_n_out, mem_ack;
  wire         host_bus_grant_n_out, host_bus_grant_oe_n_out, host_access_ready_out;
  wire         host_access_ready_oe_n_out, access_done_out, access_stall_out;
  wire         slave_access_out, slave_write_out, host_grant_seen_out, bus_yield_out;
  int          error_cnt, n_tests, cyc, i;
  logic [39:0] rows [0:6];
  // Pin levels resolved from every driver's enable
  wire read_strobe_n_in = bus_oe_n_out ? ext_rd_n : read_strobe_n_out;
  wire write_strobe_n_in = bus_oe_n_out ? ext_wr_n : write_strobe_n_out;
  wire early_write_select_n_in = bus_oe_n_out ? ext_sw_n : early_write_select_n_out;
  wire ack_in = ack_oe_n_out ? mem_ack : ack_out;
  wire host_bus_grant_n_in = host_bus_grant_oe_n_out | host_bus_grant_n_out;
  ext_bus_ctrl dut (.*);
  ext_mem_model mem (.clk_in(clk_in), .rst_in(rst_in), .read_strobe_n_in(read_strobe_n_out),
    .write_strobe_n_in(write_strobe_n_out), .bank_n_in(memory_bank_select_n_out),
    .wait_in(mem_wait), .ack_out(mem_ack));
  // Clock and hang guard
  initial begin
    clk_in = 0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      final_report;
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task final_report;
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask
  // Row: write, cond, address, waits, page check, page expected
  task acc(input logic [39:0] r);
    logic rd, wr, sw, pg;
    logic [3:0] bk;
    int k;
    rd = 1; wr = 1; sw = 1; pg = 0; bk = 4'hF;
    {req_write_in, req_cond_in, req_addr_in, mem_wait} = r[39:2];
    req_in = 1;
    for (k = 0; k < 80 && (k == 0 || access_done_out !== 1'b1); k++) begin
      @(negedge clk_in);
      rd &= read_strobe_n_out; wr &= write_strobe_n_out; sw &= early_write_select_n_out;
      bk &= memory_bank_select_n_out; pg |= page_out;
    end
    req_in = 0;
    chk("done", 1, access_done_out);
    chk("read strobe", !(r[38] && !r[39]), rd);
    chk("write strobe", !(r[38] && r[39]), wr);
    chk("early write", !r[39], sw);
    chk("bank", r[37:6] >= `EXT_BASE ? 4'(~(4'h1 << r[33:32])) : 4'hF, bk);
    chk("address", r[37:6], address_out);
    if (r[1]) chk("page", r[0], pg);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    error_cnt = 0; n_tests = 0; cyc = 0; rst_in = 1; is_master_in = 1; req_in = 0;
    req_write_in = 0; req_cond_in = 1; req_addr_in = 0; page_size_in = 0; slave_hit_in = 0;
    multiproc_bus_request_n_in = 6'h3F; mem_wait = 0; suspend_bus_tristate_n_in = 1;
    host_bus_request_n_in = 1; host_select_proc_a_n_in = 1; host_select_proc_b_n_in = 1;
    host_select_proc_c_n_in = 1; host_select_proc_d_n_in = 1; ext_rd_n = 1; ext_wr_n = 1;
    ext_sw_n = 1;
    rows[0] = {2'b01, 32'h0040_0000, 4'h0, 2'b00};
    rows[1] = {2'b11, 32'h0040_0010, 4'h8, 2'b10};
    rows[2] = {2'b01, 32'h0040_0100, 4'h0, 2'b11};
    rows[3] = {2'b11, 32'h0440_0100, 4'h4, 2'b10};
    rows[4] = {2'b01, 32'h0840_0000, 4'h2, 2'b10};
    rows[5] = {2'b10, 32'h0C40_0000, 4'h0, 2'b10};
    rows[6] = {2'b01, 32'h0002_0000, 4'h6, 2'b10};
    repeat (12) @(negedge clk_in);
    chk("reset banks", 4'hF, memory_bank_select_n_out);
    chk("reset float", 1, bus_oe_n_out);
    rst_in = 0;
    @(negedge clk_in);
    for (i = 0; i < 7; i++) acc(rows[i]);
    // Access held off by suspend, finished after release
    suspend_bus_tristate_n_in = 0;
    fork
      acc({2'b01, 32'h0440_0000, 4'h0, 2'b00});
      begin
        repeat (8) @(negedge clk_in);
        chk("stall", 1, access_stall_out);
        chk("suspend float", 1, bus_oe_n_out);
        suspend_bus_tristate_n_in = 1;
      end
    join
    // Host request beats a processor request
    host_bus_request_n_in = 0; host_select_proc_a_n_in = 0; multiproc_bus_request_n_in = 6'h3E;
    for (i = 0; i < 20 && host_bus_grant_n_out !== 1'b0; i++) @(negedge clk_in);
    chk("grant", 0, host_bus_grant_n_out);
    chk("ready enable", 0, host_access_ready_oe_n_out);
    chk("yield", 0, bus_yield_out);
    host_bus_request_n_in = 1;
    repeat (5) @(negedge clk_in);
    chk("grant release", 1, host_bus_grant_n_out);
    chk("yield", 1, bus_yield_out);
    // Slave side: outsider writes then reads our memory
    multiproc_bus_request_n_in = 6'h3F; host_select_proc_a_n_in = 1; is_master_in = 0;
    slave_hit_in = 1;
    repeat (3) @(negedge clk_in);
    ext_sw_n = 0; ext_wr_n = 0;
    repeat (6) @(negedge clk_in);
    chk("slave write", 1, slave_write_out);
    ext_sw_n = 1; ext_wr_n = 1;
    repeat (4) @(negedge clk_in);
    ext_rd_n = 0;
    repeat (6) @(negedge clk_in);
    chk("slave read", 0, slave_write_out);
    final_report;
  end
endmodule

// >>> verification/ext_mem_model.sv
// External memory that stretches each access with wait states
`timescale 1ns/1ns
module ext_mem_model (
  input  wire       clk_in,           // System clock
  input  wire       rst_in,           // Synchronous reset
  input  wire       read_strobe_n_in, // Read strobe pin
  input  wire       write_strobe_n_in,// Write strobe pin
  input  wire [3:0] bank_n_in,        // Bank selects
  input  wire [3:0] wait_in,          // Wait cycles asked
  output reg        ack_out           // Acknowledge, pull-up level idle
);
  reg [3:0] cnt_q;
  // Ack low from select on when wait_in is nonzero, since a late low is missed by the synchroniser
  always @(negedge clk_in) begin
    if (rst_in || (bank_n_in == 4'hF && read_strobe_n_in && write_strobe_n_in)) begin
      cnt_q   <= 4'h0;
      ack_out <= 1'b1;
    end else begin
      ack_out <= (cnt_q >= wait_in);
      if (cnt_q < wait_in) cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// >>> verilog/dram_row_tracker.v
// Remembers the last DRAM row opened in bank 0 and flags row changes
`timescale 1ns/1ns
`include "ext_bus_map.vh"
module dram_row_tracker (
  input  wire                    clk_in,       // System clock
  input  wire                    rst_in,       // Synchronous reset, high
  input  wire                    update_in,    // Bank 0 access starts
  input  wire [31:0]             addr_in,      // Access address
  input  wire [`PAGE_SIZE_W-1:0] page_size_in, // Page size code
  output wire                    crossed_out   // Row differs from last one
);

  reg        seen_q;
  reg [31:0] row_q;
  wire [31:0] row_now;

  // Row number is the address above the column bits
  assign row_now     = addr_in >> (`PAGE_BASE_BITS + page_size_in);
  // First access after reset always counts as a new page
  assign crossed_out = ~seen_q | (row_now != row_q);

  // ----------------------------------------------------------------
  // Row register
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rst_in) begin
      seen_q <= 1'b0;
      row_q  <= 32'h0000_0000;
    end else if (update_in) begin
      seen_q <= 1'b1;
      row_q  <= row_now;
    end
  end

endmodule

// >>> verilog/ext_bus_ctrl.v
// Shared external bus control: strobes, selects, acknowledge, host grant
// Summary of operation
// R1: Read strobe low for external and internal reads
// R2: Outsiders assert read strobe to read us
// R3: Only bus master drives the strobes
// R4: Write strobe low for external and internal writes
// R5: Outsiders assert write strobe to write us
// R6: Page output flags DRAM row crossing, master only
// R7: Page output only for bank 0 accesses
// R8: Only bus master drives clock reference
// R9: Early write select warns; no strobe aborts
// R10: Early write select starts with address
// R11: Slaves sample early write select for direction
// R12: Host asserts early write select for writes
// R13: Low acknowledge holds off access completion
// R14: Slave drives acknowledge low for wait states
// R15: Master keeps last acknowledge level
// R16: Suspend floats bus lines from next cycle; the code floats them on the third clock edge after the pin falls
// R17: Access under suspend stalls until release
// R18: Suspend only for deadlock or DRAM controller
// R19: Host request floats bus, then grants
// R20: Host request beats multiprocessor requests
// R21: Grant held low until host releases
// R22: Host chip select picks one processor
// R23: Ready driven only with select and request
// R24: Bank selects idle without external access
`timescale 1ns/1ns
`include "ext_bus_map.vh"
module ext_bus_ctrl (
  input  wire                    clk_in,                       // 20 MHz clock
  input  wire                    rst_in,                       // Synchronous reset
  input  wire                    is_master_in,                 // This end owns the bus
  input  wire                    req_in,                       // Processor access request
  input  wire                    req_write_in,                 // Request is a write
  input  wire                    req_cond_in,                  // Condition true
  input  wire [31:0]             req_addr_in,                  // Request address
  input  wire [`PAGE_SIZE_W-1:0] page_size_in,                 // DRAM page size code
  input  wire                    slave_hit_in,                 // Bus address hits us
  input  wire                    read_strobe_n_in,             // Read strobe pin
  input  wire                    write_strobe_n_in,            // Write strobe pin
  input  wire                    early_write_select_n_in,      // Early write pin
  input  wire                    ack_in,                       // Acknowledge pin
  input  wire                    suspend_bus_tristate_n_in,    // Suspend pin
  input  wire                    host_bus_request_n_in,        // Host request pin
  input  wire                    host_bus_grant_n_in,          // Grant pin level
  input  wire                    host_select_proc_a_n_in,      // Host select A
  input  wire                    host_select_proc_b_n_in,      // Host select B
  input  wire                    host_select_proc_c_n_in,      // Host select C
  input  wire                    host_select_proc_d_n_in,      // Host select D
  input  wire [5:0]              multiproc_bus_request_n_in,   // Processor requests
  output reg  [31:0]             address_out,                  // Address pins
  output reg  [3:0]              memory_bank_select_n_out,     // Bank selects
  output reg                     read_strobe_n_out,            // Read strobe drive
  output reg                     write_strobe_n_out,           // Write strobe drive
  output reg                     early_write_select_n_out,     // Early write drive
  output reg                     page_out,                     // DRAM page crossing
  output reg                     bus_clock_reference_out,      // Clock reference
  output reg                     bus_oe_n_out,                 // Bus lines enable, low
  output reg                     ack_out,                      // Acknowledge drive
  output reg                     ack_oe_n_out,                 // Acknowledge enable
  output reg                     host_bus_grant_n_out,         // Grant drive
  output reg                     host_bus_grant_oe_n_out,      // Grant enable
  output reg                     host_access_ready_out,        // Ready drive
  output reg                     host_access_ready_oe_n_out,   // Ready enable
  output reg                     access_done_out,              // Access finished pulse
  output reg                     access_stall_out,             // Processor stalled
  output reg                     slave_access_out,             // Slave access pulse
  output reg                     slave_write_out,              // Slave access is write
  output reg                     host_grant_seen_out,          // Grant seen on pin
  output reg                     bus_yield_out                 // Free for processors
);
  // ----------
  // Bank decode, used for selects and for the DRAM check
  // ----------
  function [1:0] bank_of;
    input [31:0] addr;
    bank_of = addr[`BANK_HI:`BANK_LO];
  endfunction
  // ----------
  // Pin synchronisers
  // ----------
  wire [`SYNC_W-1:0] pins_s;
  pin_sync #(
    .WIDTH (`SYNC_W)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({multiproc_bus_request_n_in, host_select_proc_d_n_in, host_select_proc_c_n_in,
                host_select_proc_b_n_in, host_select_proc_a_n_in, host_bus_grant_n_in,
                host_bus_request_n_in, suspend_bus_tristate_n_in, ack_in,
                early_write_select_n_in, write_strobe_n_in, read_strobe_n_in}),
    .sync_out (pins_s)
  );
  wire rd_s   = ~pins_s[`SY_RD];
  wire wr_s   = ~pins_s[`SY_WR];
  wire sw_s   = ~pins_s[`SY_SW];
  wire suspend_bus_tristate_n_s = ~pins_s[`SY_SUSPEND_BUS_TRISTATE_N];
  wire hbr_s  = ~pins_s[`SY_HBR];
  wire cs_s   = ~&pins_s[`SY_CS_HI:`SY_CS_LO];        // see R22
  wire br_s   = ~&pins_s[`SY_BR_HI:`SY_BR_LO];
  // ----------
  // State and held request
  // ----------
  reg [`ST_W-1:0]  state_q, state_d;
  reg [`CNT_W-1:0] cnt_q, cnt_d, scnt_q, scnt_d, hcnt_q, hcnt_d;
  reg [31:0]       addr_q, address_d;
  reg              write_q, cond_q, ack_keep_q, sbusy_q, sbusy_d, hstrobe_q;
  reg [3:0]        bank_n_d;
  reg              rd_n_d, wr_n_d, sw_n_d, page_d, bus_oe_n_d;
  reg              ack_d, ack_oe_n_d, hbg_n_d, rdy_d, rdy_oe_n_d;
  reg              done_d, stall_d, slv_acc_d, slv_wr_d;
  wire dram_start;
  wire crossed;
  wire [31:0] start_addr = (state_q == `ST_IDLE) ? req_addr_in : addr_q;
  // Only bank 0 accesses update and test the open row
  assign dram_start = (state_d == `ST_ADDR) && (state_q != `ST_ADDR) &&
                      (start_addr >= `EXT_BASE) &&
                      (bank_of(start_addr) == `BANK_DRAM);  // see R7
  dram_row_tracker u_row (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .update_in    (dram_start),
    .addr_in      (start_addr),
    .page_size_in (page_size_in),
    .crossed_out  (crossed)
  );
  // ----------
  // Master sequencing
  // ----------
  always @* begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    address_d  = address_out;
    bank_n_d   = memory_bank_select_n_out;
    rd_n_d     = 1'b1;
    wr_n_d     = 1'b1;
    sw_n_d     = early_write_select_n_out;
    page_d     = 1'b0;
    hbg_n_d    = 1'b1;
    done_d     = 1'b0;
    stall_d    = 1'b0;
    case (state_q)
      `ST_IDLE: begin
        bank_n_d = `BANK_NONE;                              // see R24
        sw_n_d   = 1'b1;
        if (is_master_in && hbr_s) begin
          state_d = `ST_RELEASE;                            // see R20
        end else if (is_master_in && req_in) begin
          if (suspend_bus_tristate_n_s) begin
            state_d = `ST_SUSP;                             // see R17
            stall_d = 1'b1;
          end else begin
            state_d = `ST_ADDR;
          end
        end
      end
      `ST_ADDR: begin
        if (suspend_bus_tristate_n_s) begin
          state_d  = `ST_SUSP;                              // see R17
          stall_d  = 1'b1;
          bank_n_d = `BANK_NONE;
        end else if (!cond_q) begin
          state_d  = `ST_IDLE;                              // see R9
          done_d   = 1'b1;
          sw_n_d   = 1'b1;
          bank_n_d = `BANK_NONE;
        end else begin
          state_d = `ST_STROBE;
          cnt_d   = `STROBE_MIN;
          rd_n_d  = write_q;                                // see R1
          wr_n_d  = ~write_q;                               // see R4
        end
      end
      `ST_STROBE: begin
        if (suspend_bus_tristate_n_s) begin
          state_d  = `ST_SUSP;                              // see R17
          stall_d  = 1'b1;
          bank_n_d = `BANK_NONE;
        end else if (cnt_q != `CNT_ZERO) begin
          cnt_d  = cnt_q - `CNT_ONE;
          rd_n_d = read_strobe_n_out;
          wr_n_d = write_strobe_n_out;
        end else if (!ack_keep_q) begin
          stall_d = 1'b1;                                   // see R13
          rd_n_d  = read_strobe_n_out;
          wr_n_d  = write_strobe_n_out;
        end else begin
          state_d  = `ST_IDLE;
          done_d   = 1'b1;
          sw_n_d   = 1'b1;
          bank_n_d = `BANK_NONE;                            // see R24
        end
      end
      `ST_SUSP: begin
        stall_d = 1'b1;
        if (!suspend_bus_tristate_n_s) state_d = `ST_ADDR;                    // see R17
      end
      `ST_RELEASE: begin
        state_d = `ST_GRANT;                                // see R19
        hbg_n_d = 1'b0;
      end
      `ST_GRANT: begin
        hbg_n_d = 1'b0;                                     // see R21
        if (!hbr_s) begin
          state_d = `ST_IDLE;
          hbg_n_d = 1'b1;
        end
      end
      default: state_d = `ST_IDLE;
    endcase
    // Address, selects and early write all appear together
    if (state_d == `ST_ADDR && state_q != `ST_ADDR) begin
      address_d = start_addr;
      bank_n_d  = (start_addr >= `EXT_BASE) ? ~(4'h1 << bank_of(start_addr)) : `BANK_NONE;
      sw_n_d = (state_q == `ST_IDLE) ? ~req_write_in : ~write_q; // see R10
      page_d = dram_start & crossed;                        // see R6
    end
    // Float only when not master, suspended or handed to the host
    bus_oe_n_d = ~is_master_in | suspend_bus_tristate_n_s |
                 (state_d == `ST_SUSP) | (state_d == `ST_RELEASE) |
                 (state_d == `ST_GRANT);                    // see R3 R16 R19
  end
  // ----------
  // Slave acknowledge and host ready
  // ----------
  always @* begin
    scnt_d     = scnt_q;
    sbusy_d    = sbusy_q;
    ack_d      = 1'b1;
    ack_oe_n_d = 1'b1;
    slv_acc_d  = 1'b0;
    slv_wr_d   = slave_write_out;
    hcnt_d     = hcnt_q;
    rdy_d      = 1'b1;
    rdy_oe_n_d = 1'b1;
    // Strobes from outside mark an access to our memory
    if (!is_master_in && slave_hit_in && (rd_s | wr_s) && !sbusy_q) begin
      sbusy_d    = 1'b1;
      scnt_d     = `SLAVE_WAIT;
      ack_d      = 1'b0;                                    // see R14
      ack_oe_n_d = 1'b0;
      slv_acc_d  = 1'b1;
      slv_wr_d   = sw_s | wr_s;                             // see R11 R5 R2
    end else if (sbusy_q && scnt_q != `CNT_ZERO) begin
      scnt_d     = scnt_q - `CNT_ONE;
      ack_d      = 1'b0;                                    // see R14
      ack_oe_n_d = 1'b0;
    end else if (sbusy_q && ack_oe_n_out == 1'b0 && ack_out == 1'b0) begin
      ack_oe_n_d = 1'b0;                                    // Drive high once, then float
    end else if (sbusy_q && !(rd_s | wr_s)) sbusy_d = 1'b0;
    // Ready only exists while a select and the host request are both low
    if (cs_s && hbr_s) begin
      rdy_oe_n_d = 1'b0;                                    // see R23
      if ((rd_s | wr_s) && !hstrobe_q) begin
        hcnt_d = `HOST_WAIT;
        rdy_d  = 1'b0;
      end else if (hcnt_q != `CNT_ZERO) begin
        hcnt_d = hcnt_q - `CNT_ONE;
        rdy_d  = 1'b0;
      end
    end else hcnt_d = `CNT_ZERO;
  end
  // ----------
  // Registers; every output comes from here
  // ----------
  always @(posedge clk_in) begin
    if (rst_in) begin
      state_q                    <= `ST_IDLE;
      cnt_q                      <= `CNT_ZERO;
      addr_q                     <= 32'h0000_0000;
      write_q                    <= 1'b0;
      cond_q                     <= 1'b0;
      ack_keep_q                 <= 1'b1;
      scnt_q                     <= `CNT_ZERO;
      sbusy_q                    <= 1'b0;
      hcnt_q                     <= `CNT_ZERO;
      hstrobe_q                  <= 1'b0;
      address_out                <= 32'h0000_0000;
      memory_bank_select_n_out   <= `BANK_NONE;
      read_strobe_n_out          <= 1'b1;
      write_strobe_n_out         <= 1'b1;
      early_write_select_n_out   <= 1'b1;
      page_out                   <= 1'b0;
      bus_clock_reference_out    <= 1'b0;
      bus_oe_n_out               <= 1'b1;
      ack_out                    <= 1'b1;
      ack_oe_n_out               <= 1'b1;
      host_bus_grant_n_out       <= 1'b1;
      host_bus_grant_oe_n_out    <= 1'b1;
      host_access_ready_out      <= 1'b1;
      host_access_ready_oe_n_out <= 1'b1;
      access_done_out            <= 1'b0;
      access_stall_out           <= 1'b0;
      slave_access_out           <= 1'b0;
      slave_write_out            <= 1'b0;
      host_grant_seen_out        <= 1'b0;
      bus_yield_out              <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      // Latch the request so a suspended access can be replayed
      if (state_q == `ST_IDLE && is_master_in && req_in && !hbr_s) begin
        addr_q  <= req_addr_in;
        write_q <= req_write_in;
        cond_q  <= req_cond_in;
      end
      // Keeper: holds whatever level was last seen on the pin
      ack_keep_q                 <= pins_s[`SY_ACK];        // see R15
      scnt_q                     <= scnt_d;
      sbusy_q                    <= sbusy_d;
      hcnt_q                     <= hcnt_d;
      hstrobe_q                  <= rd_s | wr_s;
      address_out                <= address_d;
      memory_bank_select_n_out   <= bank_n_d;
      read_strobe_n_out          <= rd_n_d;
      write_strobe_n_out         <= wr_n_d;
      early_write_select_n_out   <= sw_n_d;                 // see R9
      page_out                   <= page_d;
      // Half-rate reference, valid only while the bus is driven
      bus_clock_reference_out    <= ~bus_clock_reference_out; // see R8
      bus_oe_n_out               <= bus_oe_n_d;
      ack_out                    <= ack_d;
      ack_oe_n_out               <= ack_oe_n_d;
      host_bus_grant_n_out       <= hbg_n_d;
      host_bus_grant_oe_n_out    <= ~is_master_in;          // see R21
      host_access_ready_out      <= rdy_d;
      host_access_ready_oe_n_out <= rdy_oe_n_d;
      access_done_out            <= done_d;
      access_stall_out           <= stall_d;
      slave_access_out           <= slv_acc_d;
      slave_write_out            <= slv_wr_d;
      host_grant_seen_out        <= ~pins_s[`SY_HBG];
      // Processors may only take the bus when the host is not asking
      bus_yield_out              <= is_master_in & br_s & ~hbr_s &
                                    (state_d == `ST_IDLE);  // see R20
    end
  end
endmodule

// >>> verilog/ext_bus_map.vh
// Constants for the shared external bus control block
`ifndef EXT_BUS_MAP_VH
`define EXT_BUS_MAP_VH

// ----------
// Controller states
// ----------
`define ST_W          3
`define ST_IDLE       3'h0
`define ST_ADDR       3'h1
`define ST_STROBE     3'h2
`define ST_SUSP       3'h3
`define ST_RELEASE    3'h4
`define ST_GRANT      3'h5

// ----------
// Address map and bank decode
// ----------
`define EXT_BASE      32'h0040_0000
`define BANK_HI       27
`define BANK_LO       26
`define BANK_NONE     4'hF
`define BANK_DRAM     2'h0

// ----------
// DRAM row tracking
// ----------
`define PAGE_BASE_BITS 8
`define PAGE_SIZE_W    3

// ----------
// Wait counts, in clk_in cycles
// ----------
`define CNT_W         4
// Long enough for an ack low at select time to pass the synchroniser and keeper
`define STROBE_MIN    4'h3
`define SLAVE_WAIT    4'h2
`define HOST_WAIT     4'h3
`define CNT_ZERO      4'h0
`define CNT_ONE       4'h1

// ----------
// Synchronised input bundle layout
// ----------
`define SYNC_W        17
`define SY_RD         0
`define SY_WR         1
`define SY_SW         2
`define SY_ACK        3
`define SY_SUSPEND_BUS_TRISTATE_N       4
`define SY_HBR        5
`define SY_HBG        6
`define SY_CS_LO      7
`define SY_CS_HI      10
`define SY_BR_LO      11
`define SY_BR_HI      16

`endif

// >>> verilog/pin_sync.v
// Two-stage synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/1ns
module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk_in,   // System clock
  input  wire             rst_in,   // Synchronous reset, high
  input  wire [WIDTH-1:0] async_in, // Raw pin levels
  output wire [WIDTH-1:0] sync_out  // Levels after two flops
);

  // ----------------------------------------------------------------
  // One pair of flops per bit
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_q;
      reg stable_q;
      // Resets high: every bundled pin idles high
      always @(posedge clk_in) begin
        if (rst_in) begin
          meta_q   <= 1'b1;
          stable_q <= 1'b1;
        end else begin
          meta_q   <= async_in[i];
          stable_q <= meta_q;
        end
      end
      assign sync_out[i] = stable_q;
    end
  endgenerate

endmodule
